// ### logic/pcw_top.sv
// Purpose: write-side control registers of a four-port power manager
// Assumes: two-wire serial bus slave, write only; srst acts as power-on reset
// Notes: all outputs come from flip-flops
`default_nettype none
module pcw_top #(
   parameter int unsigned DISC_CYCLES = pcw_pkg::DISC_CYCLES,
   parameter int unsigned DC_DISC_CYCLES = pcw_pkg::DC_DISC_CYCLES,
   parameter int unsigned TED_CYCLES = pcw_pkg::TED_CYCLES,
   parameter int unsigned POR_CYCLES = pcw_pkg::POR_CYCLES_DEF,
   parameter logic [6:0] DEV_ADDR = pcw_pkg::DEV_ADDR_DEF,
   parameter int NPORTS = 4
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [NPORTS-1:0] load_low_pin,
   input wire logic thermal_hot_pin,
   input wire logic fault_pin,
   output logic upper_disconnect_driver,
   output logic lower_disconnect_driver,
   output logic uvov_fault_en,
   output logic thermal_shutdown,
   output logic por_active,
   output logic disc_halt,
   output logic error_delay_busy,
   output pcw_pkg::pcw_port_s [NPORTS-1:0] port_cfg,
   output logic [NPORTS-1:0] func_start,
   output logic [NPORTS-1:0] port_power,
   output logic [NPORTS-1:0] ramp_power_down,
   output logic [NPORTS-1:0] disc_active
);
   localparam int PW = $clog2(POR_CYCLES + 1);
   initial begin
      if (NPORTS != 4) $error("pcw_top: port address is two bits, NPORTS must be 4");
      if (DISC_CYCLES < 1 || DC_DISC_CYCLES < 1 || TED_CYCLES < 1 || POR_CYCLES < 1)
         $error("pcw_top: timing counts must be at least 1");
   end

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [NPORTS+3:0] pins_q;
   logic scl, sda, therm_hot, fault_s;
   logic [NPORTS-1:0] load_low;
   pcw_sync #(.W(NPORTS + 4)) u_sync (
      .mclk(mclk),
      .srst(srst),
      .d({fault_pin, thermal_hot_pin, load_low_pin, sda_pin, scl_pin}),
      .q(pins_q)
   );
   assign scl = pins_q[0];
   assign sda = pins_q[1];
   assign load_low = pins_q[NPORTS+1:2];
   assign therm_hot = pins_q[NPORTS+2];
   assign fault_s = pins_q[NPORTS+3];
   logic scl_d_ff, sda_d_ff;
   // previous filtered levels; cleared like the synchroniser so reset shows no edge
   always_ff @(posedge mclk) begin
      if (srst) begin
         scl_d_ff <= 1'b0;
         sda_d_ff <= 1'b0;
      end else begin
         scl_d_ff <= scl;
         sda_d_ff <= sda;
      end
   end
   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl && !scl_d_ff;
   assign scl_fall = !scl && scl_d_ff;
   assign bus_start = scl && scl_d_ff && sda_d_ff && !sda;
   assign bus_stop = scl && scl_d_ff && !sda_d_ff && sda;

   // ----------------------------------------------------------------------
   // serial receiver: address, command, data bytes
   // ----------------------------------------------------------------------
   pcw_pkg::pcw_bus_state_e st_ff;
   logic [7:0] shift_ff, cmd_ff, wdata_ff;
   logic [3:0] bitcnt_ff;
   logic [1:0] byte_idx_ff;
   logic wr_ff, byte_done, accept;
   assign byte_done = (st_ff == pcw_pkg::ST_RECV) && scl_fall && (bitcnt_ff == 4'h8);
   // reads are not served: a read address byte is not acknowledged
   assign accept = (byte_idx_ff != 2'h0) || (shift_ff == {DEV_ADDR, 1'b0});
   // the receiver ignores the software reset so an ack in flight is not cut
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_ff <= pcw_pkg::ST_IDLE;
         bitcnt_ff <= 4'h0;
         byte_idx_ff <= 2'h0;
         shift_ff <= 8'h00;
      end else if (bus_start) begin
         st_ff <= pcw_pkg::ST_RECV;
         bitcnt_ff <= 4'h0;
         byte_idx_ff <= 2'h0;
      end else if (bus_stop) begin
         st_ff <= pcw_pkg::ST_IDLE;
      end else begin
         case (st_ff)
            pcw_pkg::ST_RECV: begin
               if (scl_rise && bitcnt_ff != 4'h8) begin
                  shift_ff <= {shift_ff[6:0], sda};
                  bitcnt_ff <= bitcnt_ff + 4'h1;
               end
               if (byte_done) begin
                  st_ff <= accept ? pcw_pkg::ST_ACK : pcw_pkg::ST_SKIP;
                  if (byte_idx_ff != 2'h2) begin
                     byte_idx_ff <= byte_idx_ff + 2'h1;
                  end
               end
            end
            pcw_pkg::ST_ACK: begin
               if (scl_fall) begin
                  st_ff <= pcw_pkg::ST_RECV;
                  bitcnt_ff <= 4'h0;
               end
            end
            pcw_pkg::ST_SKIP: st_ff <= pcw_pkg::ST_SKIP;
            default: st_ff <= pcw_pkg::ST_IDLE;
         endcase
      end
   end
   // acknowledge drive: low enable while pulling the line low
   logic sda_oe_n_ff;
   always_ff @(posedge mclk) begin
      if (srst || bus_start || bus_stop) begin
         sda_oe_n_ff <= 1'b1;
      end else if (byte_done && accept) begin
         sda_oe_n_ff <= 1'b0;
      end else if (st_ff == pcw_pkg::ST_ACK && scl_fall) begin
         sda_oe_n_ff <= 1'b1;
      end
   end
   // command capture and one-cycle write strobe; later bytes rewrite
   always_ff @(posedge mclk) begin
      if (srst) begin
         cmd_ff <= 8'h00;
         wdata_ff <= 8'h00;
         wr_ff <= 1'b0;
      end else begin
         wr_ff <= byte_done && byte_idx_ff == 2'h2;
         if (byte_done && byte_idx_ff == 2'h1) begin
            cmd_ff <= shift_ff;
         end
         if (byte_done && byte_idx_ff == 2'h2) begin
            wdata_ff <= shift_ff;
         end
      end
   end
   logic [3:0] sel;
   logic wr_gc, wr_tr;
   assign sel = cmd_ff[pcw_pkg::CMD_SEL_MSB:pcw_pkg::CMD_SEL_LSB];
   assign wr_gc = wr_ff && sel == pcw_pkg::SEL_GLOBAL;
   assign wr_tr = wr_ff && sel == pcw_pkg::SEL_TEST;

   // ----------------------------------------------------------------------
   // global registers and software reset
   // ----------------------------------------------------------------------
   logic [7:0] gc_ff, tr_ff;
   logic soft_rst_ff, probed_ff, clr_all;
   logic [NPORTS-1:0] probe_hit;
   assign clr_all = srst || soft_rst_ff;
   // global control; thermal disable frozen once a port has been probed
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         gc_ff <= pcw_pkg::REG_RESET;
      end else if (wr_gc) begin
         gc_ff <= wdata_ff & pcw_pkg::GC_MASK;
         if (probed_ff) begin
            gc_ff[pcw_pkg::GC_THERM_DIS] <= gc_ff[pcw_pkg::GC_THERM_DIS];
         end
      end
   end
   // test override register
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         tr_ff <= pcw_pkg::REG_RESET;
      end else if (wr_tr) begin
         tr_ff <= wdata_ff & pcw_pkg::TR_MASK;
      end
   end
   // software reset pulse follows the stored bit by one cycle
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         soft_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= gc_ff[pcw_pkg::GC_SW_RESET];
      end
   end
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         probed_ff <= 1'b0;
      end else if (|probe_hit) begin
         probed_ff <= 1'b1;
      end
   end
   // reset timing cycle; hold bit keeps it released
   logic [PW-1:0] por_cnt_ff;
   logic por_ff;
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         por_cnt_ff <= '0;
         por_ff <= 1'b1;
      end else if (tr_ff[pcw_pkg::TR_POR_HOLD]) begin
         por_ff <= 1'b0;
      end else if (por_ff) begin
         por_cnt_ff <= por_cnt_ff + PW'(1);
         por_ff <= (por_cnt_ff != PW'(POR_CYCLES - 1));
      end
   end
   // all-port kill and thermal state
   logic off_ff, tsd_ff;
   always_ff @(posedge mclk) begin
      if (srst) begin
         off_ff <= 1'b1;
         tsd_ff <= 1'b0;
      end else begin
         tsd_ff <= tr_ff[pcw_pkg::TR_TSD_FORCE]
                   || (therm_hot && !gc_ff[pcw_pkg::GC_THERM_DIS]);
         off_ff <= gc_ff[pcw_pkg::GC_ALL_OFF] || por_ff
                   || tr_ff[pcw_pkg::TR_TSD_FORCE]
                   || (therm_hot && !gc_ff[pcw_pkg::GC_THERM_DIS]);
      end
   end
   // error delay; disabled means faults are released at once
   logic ted_exp, ted_busy_ff;
   pcw_timer #(.N(TED_CYCLES)) u_ted (
      .mclk(mclk),
      .srst(clr_all),
      .clr(!fault_s),
      .run(fault_s && !tr_ff[pcw_pkg::TR_TED_DIS]),
      .expired(ted_exp)
   );
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         ted_busy_ff <= 1'b0;
      end else begin
         ted_busy_ff <= fault_s && !tr_ff[pcw_pkg::TR_TED_DIS] && !ted_exp;
      end
   end

   // ----------------------------------------------------------------------
   // per-port control, discovery and power state
   // ----------------------------------------------------------------------
   logic [NPORTS-1:0] wr_p_v;
   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      pcw_pkg::pcw_port_s cfg_ff;
      logic wr_p, start_ff, rdn_ff, disc_ff, pwr_ff, disc_exp, dc_exp, dc_cond;
      logic [3:0] code;
      assign code = wdata_ff[3:0];
      assign wr_p = wr_ff && sel == pcw_pkg::SEL_PORT
                    && cmd_ff[pcw_pkg::CMD_PORT_MSB:0] == 2'(p);
      assign wr_p_v[p] = wr_p;
      assign probe_hit[p] = wr_p && (code == pcw_pkg::FN_DISC1 || code == pcw_pkg::FN_DISC2);
      // stored control fields; bits 7 and 6 are never kept
      always_ff @(posedge mclk) begin
         if (clr_all) begin
            cfg_ff <= '0;
         end else if (wr_p) begin
            cfg_ff.disc_fault_dis <= wdata_ff[pcw_pkg::PC_DISC_FAULT_DIS];
            cfg_ff.dc_disc_dis <= wdata_ff[pcw_pkg::PC_DC_DIS];
            cfg_ff.func <= code;
         end
      end
      // start strobe only for defined codes; spares give no strobe
      always_ff @(posedge mclk) begin
         if (clr_all) begin
            start_ff <= 1'b0;
            rdn_ff <= 1'b0;
         end else begin
            start_ff <= wr_p && code < pcw_pkg::FN_SPARE_FIRST;
            rdn_ff <= wr_p && code == pcw_pkg::FN_RAMP_DOWN;
         end
      end
      // discovery phase: timed, halted, or untimed per test bits
      pcw_timer #(.N(DISC_CYCLES)) u_disc (
         .mclk(mclk),
         .srst(clr_all),
         .clr(wr_p),
         .run(disc_ff && !tr_ff[pcw_pkg::TR_DISC_HALT]
              && !tr_ff[pcw_pkg::TR_DISC_TMR_DIS]),
         .expired(disc_exp)
      );
      always_ff @(posedge mclk) begin
         if (clr_all || off_ff) begin
            disc_ff <= 1'b0;
         end else if (wr_p) begin
            disc_ff <= probe_hit[p];
         end else if (disc_exp) begin
            disc_ff <= 1'b0;
         end
      end
      // low-load disconnect; dwell is the least legal time
      assign dc_cond = pwr_ff && load_low[p] && !cfg_ff.dc_disc_dis;
      pcw_timer #(.N(DC_DISC_CYCLES)) u_dc (
         .mclk(mclk),
         .srst(clr_all),
         .clr(!dc_cond),
         .run(dc_cond),
         .expired(dc_exp)
      );
      // power delivery: up on ramp-up, down on disable, ramp-down or kill
      always_ff @(posedge mclk) begin
         if (clr_all || off_ff) begin
            pwr_ff <= 1'b0;
         end else if (wr_p) begin
            pwr_ff <= code == pcw_pkg::FN_RAMP_UP ? 1'b1 :
                      code == pcw_pkg::FN_DISABLE || code == pcw_pkg::FN_RAMP_DOWN ? 1'b0 :
                      pwr_ff;
         end else if (dc_cond && (dc_exp || tr_ff[pcw_pkg::TR_DC_ZERO])) begin
            pwr_ff <= 1'b0;
         end
      end
      assign port_cfg[p] = cfg_ff;
      assign func_start[p] = start_ff;
      assign ramp_power_down[p] = rdn_ff;
      assign disc_active[p] = disc_ff;
      assign port_power[p] = pwr_ff;
   end

   // ----------------------------------------------------------------------
   // outputs straight from registers
   // ----------------------------------------------------------------------
   logic sda_out_ff;
   always_ff @(posedge mclk) begin
      sda_out_ff <= 1'b0;
   end
   assign sda_out = sda_out_ff;
   assign sda_oe_n = sda_oe_n_ff;
   assign upper_disconnect_driver = gc_ff[pcw_pkg::GC_UPPER_DRV];
   assign lower_disconnect_driver = gc_ff[pcw_pkg::GC_LOWER_DRV];
   assign uvov_fault_en = gc_ff[pcw_pkg::GC_UVOV_EN];
   assign thermal_shutdown = tsd_ff;
   assign por_active = por_ff;
   assign disc_halt = tr_ff[pcw_pkg::TR_DISC_HALT];
   assign error_delay_busy = ted_busy_ff;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   chk_tsd_force_off: assert property (@(posedge mclk) disable iff (srst)
      tr_ff[pcw_pkg::TR_TSD_FORCE] && !soft_rst_ff |=> thermal_shutdown ##1 port_power == '0)
      else $error("forced thermal shutdown did not turn ports off");
   chk_por_hold: assert property (@(posedge mclk) disable iff (srst)
      tr_ff[pcw_pkg::TR_POR_HOLD] && !soft_rst_ff |=> !por_active)
      else $error("reset hold did not release reset timing");
   chk_disc_untimed: assert property (@(posedge mclk) disable iff (srst)
      disc_active[0] && tr_ff[pcw_pkg::TR_DISC_TMR_DIS] && !wr_p_v[0] && !off_ff
      && !soft_rst_ff |=> disc_active[0])
      else $error("discovery ended while its timer was disabled");
   chk_disc_halted: assert property (@(posedge mclk) disable iff (srst)
      disc_active[1] && tr_ff[pcw_pkg::TR_DISC_HALT] && !wr_p_v[1] && !off_ff
      && !soft_rst_ff |=> disc_active[1])
      else $error("halted discovery ended");
   chk_dc_zero: assert property (@(posedge mclk) disable iff (srst)
      port_power[1] && load_low[1] && !port_cfg[1].dc_disc_dis
      && tr_ff[pcw_pkg::TR_DC_ZERO] && !wr_p_v[1] |=> !port_power[1])
      else $error("zero-time disconnect did not drop power");
   chk_ted_disabled: assert property (@(posedge mclk) disable iff (srst)
      tr_ff[pcw_pkg::TR_TED_DIS] && !soft_rst_ff |=> !error_delay_busy)
      else $error("error delay ran while disabled");
   chk_therm_lock: assert property (@(posedge mclk) disable iff (srst)
      probed_ff && wr_gc && !soft_rst_ff
      |=> gc_ff[pcw_pkg::GC_THERM_DIS] == $past(gc_ff[pcw_pkg::GC_THERM_DIS]))
      else $error("thermal disable changed after probe");
   chk_drivers: assert property (@(posedge mclk) disable iff (srst)
      wr_gc && !soft_rst_ff |=> upper_disconnect_driver == $past(wdata_ff[4])
      && lower_disconnect_driver == $past(wdata_ff[3]))
      else $error("disconnect drivers do not follow the write");
   chk_all_off: assert property (@(posedge mclk) disable iff (srst)
      gc_ff[pcw_pkg::GC_ALL_OFF] && !soft_rst_ff |-> ##2 port_power == '0)
      else $error("all-ports-off left a port powered");
   chk_soft_reset: assert property (@(posedge mclk) disable iff (srst)
      wr_gc && wdata_ff[0] && !soft_rst_ff
      |=> ##2 gc_ff == 8'h00 && tr_ff == 8'h00 && por_active)
      else $error("software reset did not clear and restart");
   chk_func_disable: assert property (@(posedge mclk) disable iff (srst)
      wr_p_v[1] && wdata_ff[3:0] == pcw_pkg::FN_DISABLE |=> !port_power[1] && !disc_active[1])
      else $error("disable code left the port active");
   chk_spare_code: assert property (@(posedge mclk) disable iff (srst)
      wr_p_v[3] && !soft_rst_ff |=> func_start[3] == ($past(wdata_ff[3:0]) < 4'hd))
      else $error("start strobe wrong for the written code");
endmodule
`default_nettype wire

// ### logic/pcw_pkg.sv
// Purpose: shared constants and types for the power manager write registers
// Assumes: 40 MHz mclk, synchronous active-high reset
// Notes: field positions are bit numbers inside the 8-bit command or data byte
`default_nettype none
package pcw_pkg;
   // ----------------------------------------------------------------------
   // command byte layout and register selects
   // ----------------------------------------------------------------------
   localparam int CMD_SEL_MSB = 6;
   localparam int CMD_SEL_LSB = 3;
   localparam int CMD_PORT_MSB = 1;
   localparam logic [3:0] SEL_GLOBAL = 4'h1;
   localparam logic [3:0] SEL_PORT = 4'h2;
   localparam logic [3:0] SEL_TEST = 4'hf;
   localparam logic [7:0] REG_RESET = 8'h00;
   // global_control fields
   localparam int GC_THERM_DIS = 5;
   localparam int GC_UPPER_DRV = 4;
   localparam int GC_LOWER_DRV = 3;
   localparam int GC_UVOV_EN = 2;
   localparam int GC_ALL_OFF = 1;
   localparam int GC_SW_RESET = 0;
   localparam logic [7:0] GC_MASK = 8'h3f;
   // test_override fields
   localparam int TR_TSD_FORCE = 6;
   localparam int TR_POR_HOLD = 5;
   localparam int TR_DISC_TMR_DIS = 4;
   localparam int TR_DISC_HALT = 3;
   localparam int TR_DC_ZERO = 2;
   localparam int TR_TED_DIS = 1;
   localparam logic [7:0] TR_MASK = 8'h7e;
   // port_function_control fields
   localparam int PC_DISC_FAULT_DIS = 5;
   localparam int PC_DC_DIS = 4;
   // ----------------------------------------------------------------------
   // function codes and timing
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      FN_DISABLE = 4'h0, FN_DISC1 = 4'h1, FN_DISC2 = 4'h2, FN_VSAMPLE = 4'h3,
      FN_LEGACY = 4'h4, FN_CLASSIFY = 4'h5, FN_RAMP_UP = 4'h6, FN_CSAMPLE = 4'h7,
      FN_RAMP_DOWN = 4'h8, FN_AC_LOW = 4'h9, FN_AC_HIGH = 4'ha, FN_ISAMPLE = 4'hb,
      FN_TSAMPLE = 4'hc, FN_SPARE_FIRST = 4'hd
   } pcw_func_e;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned DISC_TIME_MS = 4;
   localparam int unsigned DC_DISC_MIN_MS = 300;
   localparam int unsigned DC_DISC_MAX_MS = 400;
   localparam int unsigned TED_TIME_MS = 750;
   localparam int unsigned DISC_CYCLES = DISC_TIME_MS * CYC_PER_MS;
   localparam int unsigned DC_DISC_CYCLES = DC_DISC_MIN_MS * CYC_PER_MS;
   localparam int unsigned TED_CYCLES = TED_TIME_MS * CYC_PER_MS;
   localparam int unsigned POR_CYCLES_DEF = 64;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
   // ----------------------------------------------------------------------
   // carriers and states
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic disc_fault_dis;
      logic dc_disc_dis;
      logic [3:0] func;
   } pcw_port_s;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_RECV = 4'b0010, ST_ACK = 4'b0100, ST_SKIP = 4'b1000
   } pcw_bus_state_e;
endpackage
`default_nettype wire

// ### logic/pcw_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk
// Notes: output follows only when stages two and three agree
`default_nettype none
module pcw_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
   // ----------------------------------------------------------------------
   // chain; the first stage feeds only the second
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & q_ff);
      end
   end
   assign q = q_ff;
endmodule
`default_nettype wire

// ### logic/pcw_timer.sv
// Purpose: run-time accumulator that flags after N running cycles
// Assumes: clr has priority over run
// Notes: expired stays high until clr
`default_nettype none
module pcw_timer #(
   parameter int unsigned N = 16
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic clr,
   input wire logic run,
   output logic expired
);
   localparam int CW = $clog2(N + 1);
   logic [CW-1:0] cnt_ff;
   logic exp_ff;
   initial begin
      if (N < 1) $error("pcw_timer: N must be at least 1");
   end
   // counts only while run; holding run low freezes the count
   always_ff @(posedge mclk) begin
      if (srst || clr) begin
         cnt_ff <= '0;
         exp_ff <= 1'b0;
      end else if (run && !exp_ff) begin
         cnt_ff <= cnt_ff + CW'(1);
         exp_ff <= (cnt_ff == CW'(N - 1));
      end
   end
   assign expired = exp_ff;
endmodule
`default_nettype wire

// ### bench/pcw_host.sv
// Purpose: host model, two-wire bus write master
// Assumes: paced by mclk, one bus bit every 24 cycles
// Notes: open-drain data line, pulled up when nobody pulls low
`default_nettype none
module pcw_host (
   input wire logic mclk,
   input wire logic sda_oe_n,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv_ff = 1'b1;
   int nacks = 0;
   initial scl = 1'b1;
   // wire level: low if either side pulls, pull-up otherwise
   assign sda = drv_ff & sda_oe_n;
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // data changes only while the clock is low
   task automatic bit_out(input logic v);
      drv_ff = v;
      tick(6);
      scl = 1'b1;
      tick(12);
      scl = 1'b0;
      tick(6);
   endtask
   // msb first, ack sampled mid high phase of the ninth clock
   task automatic byte_out(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      drv_ff = 1'b1;
      tick(6);
      scl = 1'b1;
      tick(6);
      nacks += int'(sda !== 1'b0); // an unknown line counts as no ack
      tick(6);
      scl = 0;
      tick(6);
   endtask
   // start, address, command, data, stop; test writes only on request
   task automatic xfer(input logic [7:0] ad, input logic [7:0] cmd, input logic [7:0] d);
      nacks = 0;
      drv_ff = 1'b0;
      tick(12);
      scl = 1'b0;
      tick(6);
      byte_out(ad);
      byte_out(cmd);
      byte_out(d);
      drv_ff = 1'b0;
      tick(6);
      scl = 1'b1;
      tick(12);
      drv_ff = 1'b1;
      tick(12);
   endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: bench for the power manager write registers
// Assumes: pcw_host drives the serial bus
// Notes: long counts shortened by parameters
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: %0h vs %0h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 0, srst = 1, hot = 0, flt = 0, scl_pin, sda_pin, sda_oe_n;
   logic ud, ld, uv, ts, por, dh, eb;
   logic [3:0] low = '0, pwr, fs, seen = '0, rdn, rseen = '0, da;
   pcw_pkg::pcw_port_s [3:0] cfg;
   int error_cnt = 0, num_checks = 0;
   always #12.5 mclk = ~mclk;
   // sticky record of start and ramp-down pulses, one cycle wide each
   always @(posedge mclk) begin
      seen <= seen | fs;
      rseen <= rseen | rdn;
   end
   pcw_top #(.DISC_CYCLES(20), .DC_DISC_CYCLES(30), .TED_CYCLES(40), .POR_CYCLES(200)) i_pcw_top (
      .mclk, .srst, .scl_pin, .sda_pin, .sda_out(), .sda_oe_n, .load_low_pin(low),
      .thermal_hot_pin(hot), .fault_pin(flt), .upper_disconnect_driver(ud),
      .lower_disconnect_driver(ld), .uvov_fault_en(uv), .thermal_shutdown(ts), .por_active(por),
      .disc_halt(dh), .error_delay_busy(eb), .port_cfg(cfg), .func_start(fs), .port_power(pwr),
      .ramp_power_down(rdn), .disc_active(da));
   pcw_host i_pcw_host (.mclk, .sda_oe_n, .scl(scl_pin), .sda(sda_pin));
   task automatic wr(input logic [3:0] sel, input logic [1:0] p, input logic [7:0] d);
      i_pcw_host.xfer({pcw_pkg::DEV_ADDR_DEF, 1'b0}, {1'b0, sel, 1'b0, p}, d);
      `CHK(i_pcw_host.nacks, 0)
   endtask
   task automatic sc_reset;
      `CHK({ud, ld, uv, ts, dh, cfg, por}, 30'h1)
      i_pcw_host.tick(220);
      `CHK(por, 1'b0)
   endtask
   task automatic sc_global;
      wr(4'h1, 2'd0, 8'hdc);
      `CHK({ud, ld, uv}, 3'b111)
      wr(4'h1, 2'd0, 8'h10);
      wr(4'h3, 2'd0, 8'h00);
      `CHK({ud, ld, uv}, 3'b100)
   endtask
   // unused D7/D6 set on purpose; every code on a rotating port
   task automatic sc_codes;
      for (int c = 0; c < 16; c++) begin
         seen = '0;
         rseen = '0;
         wr(4'h2, c[1:0], {2'b11, c[0], c[1], c[3:0]});
         `CHK(cfg[c[1:0]], {c[0], c[1], c[3:0]})
         `CHK(seen[c[1:0]], c < 13)
         `CHK(rseen[c[1:0]], c == 8)
      end
   endtask
   // thermal disable may change before any probe, not after
   task automatic sc_lock;
      wr(4'h1, 2'd0, 8'h20);
      hot = 1'b1;
      i_pcw_host.tick(8);
      `CHK(ts, 1'b0)
      wr(4'h1, 2'd0, 8'h00);
      `CHK(ts, 1'b1)
      sc_codes;
      wr(4'h1, 2'd0, 8'h20);
      `CHK(ts, 1'b1)
      hot = 1'b0;
   endtask
   // a powered port losing power by ramp-down, disable, all-off, forced thermal shutdown and both disconnect dwells
   task automatic sc_power;
      wr(4'h2, 2'd1, 8'h06);
      `CHK(pwr[1], 1'b1)
      wr(4'h2, 2'd1, 8'h08);
      `CHK({pwr[1], rseen[1]}, 2'b01)
      wr(4'h2, 2'd1, 8'h06);
      wr(4'h2, 2'd1, 8'h00);
      `CHK(pwr[1], 1'b0)
      wr(4'h2, 2'd1, 8'h06);
      wr(4'h1, 2'd0, 8'h02);
      `CHK(pwr[1], 1'b0)
      wr(4'h1, 2'd0, 8'h00);
      wr(4'h2, 2'd1, 8'h06);
      wr(4'hf, 2'd0, 8'h48);
      `CHK({ts, dh, pwr[1]}, 3'b110)
      wr(4'hf, 2'd0, 8'h00);
      wr(4'h2, 2'd1, 8'h06);
      low[1] = 1'b1;
      i_pcw_host.tick(10);
      `CHK(pwr[1], 1'b1)
      i_pcw_host.tick(30);
      `CHK(pwr[1], 1'b0)
      low[1] = 1'b0;
      wr(4'hf, 2'd0, 8'h04);
      wr(4'h2, 2'd1, 8'h06);
      low[1] = 1'b1;
      i_pcw_host.tick(10);
      `CHK(pwr[1], 1'b0)
      low[1] = 1'b0;
   endtask
   // a held fault runs the delay out; with the disable bit it never starts
   task automatic sc_fault;
      flt = 1'b1;
      i_pcw_host.tick(10);
      `CHK(eb, 1'b1)
      i_pcw_host.tick(50);
      `CHK(eb, 1'b0)
      flt = 1'b0;
      wr(4'hf, 2'd0, 8'h02);
      flt = 1'b1;
      i_pcw_host.tick(10);
      `CHK(eb, 1'b0)
      flt = 1'b0;
   endtask
   // discovery outlives its time while timers are off or halted, ends once they run
   task automatic sc_disc;
      wr(4'hf, 2'd0, 8'h10);
      wr(4'h2, 2'd0, 8'h01);
      wr(4'hf, 2'd0, 8'h08);
      wr(4'h2, 2'd1, 8'h02);
      i_pcw_host.tick(40);
      `CHK({da[1:0], dh}, 3'b111)
      wr(4'hf, 2'd0, 8'h00);
      `CHK({da[1:0], dh}, 3'b000)
   endtask
   task automatic sc_swreset;
      wr(4'h1, 2'd0, 8'h19);
      `CHK({ud, ld, por, cfg[1]}, 9'h040)
      for (int i = 0; i < 250 && por; i++) i_pcw_host.tick(1);
      `CHK(por, 1'b0)
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      srst = 1'b0;
      sc_reset;
      sc_global;
      sc_lock;
      sc_power;
      sc_fault;
      sc_disc;
      sc_swreset;
      wrap_up;
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      wrap_up;
   end
endmodule
`default_nettype wire
